// ==== verilog/secure_memory_attribution_checker.sv ====
// checks processor memory accesses against security attribution of eight regions
`timescale 1ns/1ns
module secure_memory_attribution_checker #(
	parameter bit SEC_EXT = 1'b1
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// region table from nonvolatile memory
	input wire logic nvm_load,
	input wire logic secure_development_lifecycle_state,
	input wire logic [8*32-1:0] nvm_base,
	input wire logic [8*32-1:0] nvm_limit,
	input wire logic [8*2-1:0] nvm_kind,
	input wire logic [8*2-1:0] nvm_attr,
	// processor access
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_handler,
	input wire logic [31:0] req_addr,
	input wire logic [31:0] mem_rdata,
	output logic mem_valid,
	output logic [31:0] req_rdata,
	output logic fault_pulse,
	// fault resolution, status interrupt and cpu security state
	output logic fault_reset,
	output logic fault_nmi,
	output logic irq,
	output logic cpu_secure
);
	// region table
	logic [31:0] base_q [attr_pkg::NUM_REGIONS];
	logic [31:0] limit_q [attr_pkg::NUM_REGIONS];
	logic [1:0] kind_q [attr_pkg::NUM_REGIONS];
	logic [1:0] attr_q [attr_pkg::NUM_REGIONS];
	logic [attr_pkg::NUM_REGIONS-1:0] hit;
	logic [2:0] ctrl_q;
	logic [attr_pkg::ST_W-1:0] status_q;
	logic [attr_pkg::ST_W-1:0] mask_q;
	logic [7:0] prot_tmp_q;
	logic [7:0] prot_perm_q;
	logic sec_q;
	logic pe_mode_q;

	// table loads only in development lifecycle; software cannot write it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < attr_pkg::NUM_REGIONS; i++) begin
				base_q[i] <= 32'h0;
				limit_q[i] <= 32'h0;
				kind_q[i] <= attr_pkg::KIND_NONE;
				attr_q[i] <= attr_pkg::ATTR_SECURE;
			end
		end else if (clk_en && nvm_load && secure_development_lifecycle_state) begin
			for (int i = 0; i < attr_pkg::NUM_REGIONS; i++) begin
				base_q[i] <= nvm_base[i*32 +: 32];
				limit_q[i] <= nvm_limit[i*32 +: 32];
				kind_q[i] <= nvm_kind[i*2 +: 2];
				attr_q[i] <= nvm_attr[i*2 +: 2];
			end
		end
	end

	// region match, combinational so the check lands in the decode cycle
	genvar g;
	generate
		for (g = 0; g < attr_pkg::NUM_REGIONS; g++) begin : g_hit
			assign hit[g] = (kind_q[g] != attr_pkg::KIND_NONE) &&
				(req_addr >= base_q[g]) && (req_addr <= limit_q[g]);
		end
	endgenerate

	// lowest region wins; unmatched addresses count as secure, fail closed
	logic [1:0] hit_attr;
	logic [1:0] hit_kind;
	logic [2:0] hit_idx;
	always_comb begin
		hit_attr = attr_pkg::ATTR_SECURE;
		hit_kind = attr_pkg::KIND_NONE;
		hit_idx = 3'h0;
		for (int i = attr_pkg::NUM_REGIONS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hit_attr = attr_q[i];
				hit_kind = kind_q[i];
				hit_idx = 3'(i);
			end
		end
	end

	// handler/thread mode plays no part in the decision
	wire unused_mode = req_handler;
	wire is_flash = (hit_kind == attr_pkg::KIND_CFLASH) || (hit_kind == attr_pkg::KIND_DFLASH);
	wire is_sram = (hit_kind == attr_pkg::KIND_SRAM);
	wire ns_target = (hit_attr == attr_pkg::ATTR_NONSEC);
	// secure side reaches all, nonsecure only nonsecure
	wire violate = req_valid && !sec_q && !ns_target;
	wire flash_fault = violate && is_flash && !req_write;
	wire sram_fault = violate && is_sram;
	wire other_block = violate && !is_flash && !is_sram;
	wire prot_hit = req_valid && req_write && is_flash &&
		(prot_tmp_q[hit_idx] || prot_perm_q[hit_idx]);
	wire blocked = flash_fault || sram_fault || other_block ||
		(violate && req_write) || prot_hit;
	wire sec_fault = flash_fault || sram_fault;

	assign mem_valid = req_valid && !blocked;
	assign req_rdata = blocked ? 32'h0 : mem_rdata;
	assign fault_pulse = sec_fault && clk_en;
	// fault resolution selected by ctrl
	assign fault_nmi = fault_pulse && ctrl_q[attr_pkg::CTRL_FAULT_NMI];
	assign fault_reset = fault_pulse && !ctrl_q[attr_pkg::CTRL_FAULT_NMI];
	assign cpu_secure = sec_q;
	assign irq = |(status_q & mask_q);

	// apb decode
	wire apb_wr = psel && penable && pwrite && clk_en;
	wire apb_rd = psel && penable && !pwrite;
	wire wr_ctrl = apb_wr && (paddr == attr_pkg::OFS_CTRL) && pstrb[0];
	wire wr_status = apb_wr && (paddr == attr_pkg::OFS_STATUS) && pstrb[0];
	wire wr_mask = apb_wr && (paddr == attr_pkg::OFS_MASK) && pstrb[0];
	wire wr_pe = apb_wr && (paddr == attr_pkg::OFS_PE_REQ) && pstrb[0];
	wire wr_prot = apb_wr && (paddr == attr_pkg::OFS_PROT) && pstrb[0];
	wire mapped = (paddr == attr_pkg::OFS_CTRL) || (paddr == attr_pkg::OFS_STATUS) ||
		(paddr == attr_pkg::OFS_MASK) || (paddr == attr_pkg::OFS_STATE) ||
		(paddr == attr_pkg::OFS_PE_REQ) || (paddr == attr_pkg::OFS_PROT);
	// the apb write carries the issuing security state in the live cpu state
	wire pe_allowed = sec_q || ctrl_q[attr_pkg::CTRL_PE_NS_OK];
	wire pe_try = wr_pe && pwdata[0];
	wire pe_ok = pe_try && pe_allowed;
	wire pe_bad = pe_try && !pe_allowed;
	// config writes to ctrl and protection need secure state
	wire sec_wr = sec_q;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= attr_pkg::CTRL_RST;
			mask_q <= attr_pkg::MASK_RST;
			prot_tmp_q <= attr_pkg::PROT_RST;
			prot_perm_q <= attr_pkg::PROT_RST;
		end else if (clk_en) begin
			if (wr_ctrl && sec_wr) begin
				ctrl_q <= pwdata[2:0];
			end
			if (wr_mask) begin
				mask_q <= pwdata[attr_pkg::ST_W-1:0];
			end
			// permanent bits only set, never clear until reset
			if (wr_prot && sec_wr) begin
				prot_tmp_q <= pwdata[7:0];
				prot_perm_q <= prot_perm_q | pwdata[15:8];
			end
		end
	end

	// security state: secure from reset with extension, never otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_q <= SEC_EXT;
			pe_mode_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl && sec_q && pwdata[attr_pkg::CTRL_TO_NS]) begin
				sec_q <= 1'b0;
			end
			if (pe_ok) begin
				pe_mode_q <= 1'b1;
			end else if (wr_pe && !pwdata[0]) begin
				pe_mode_q <= 1'b0;
			end
		end
	end

	// sticky status, set beats write-one-to-clear
	logic [attr_pkg::ST_W-1:0] st_set;
	assign st_set = {pe_ok, pe_bad, sec_fault};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
		end else if (clk_en) begin
			status_q <= (status_q & ~(wr_status ? pwdata[attr_pkg::ST_W-1:0] : '0)) | st_set;
		end
	end

	// read mux
	always_comb begin
		prdata = 32'h0;
		if (apb_rd) begin
			case (paddr)
				attr_pkg::OFS_CTRL: prdata = {29'h0, ctrl_q};
				attr_pkg::OFS_STATUS: prdata = {29'h0, status_q};
				attr_pkg::OFS_MASK: prdata = {29'h0, mask_q};
				attr_pkg::OFS_STATE: prdata = {30'h0, pe_mode_q, sec_q};
				attr_pkg::OFS_PE_REQ: prdata = {31'h0, pe_mode_q};
				attr_pkg::OFS_PROT: prdata = {16'h0, prot_perm_q, prot_tmp_q};
				default: prdata = 32'h0;
			endcase
		end
	end
endmodule : secure_memory_attribution_checker

// ==== verilog/attr_pkg.sv ====
// constants for the memory attribution checker
package attr_pkg;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned NUM_REGIONS = 8;
	// region kinds
	typedef enum logic [1:0] {
		KIND_CFLASH = 2'b00,
		KIND_DFLASH = 2'b01,
		KIND_SRAM = 2'b10,
		KIND_NONE = 2'b11
	} mem_kind_e;
	// attributes
	typedef enum logic [1:0] {
		ATTR_SECURE = 2'b00,
		ATTR_NSC = 2'b01,
		ATTR_NONSEC = 2'b10
	} attr_e;
	// apb register offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_MASK = 12'h008;
	localparam logic [11:0] OFS_STATE = 12'h00c;
	localparam logic [11:0] OFS_PE_REQ = 12'h010;
	localparam logic [11:0] OFS_PROT = 12'h014;
	// ctrl bit positions
	localparam int unsigned CTRL_FAULT_NMI = 0;
	localparam int unsigned CTRL_PE_NS_OK = 1;
	localparam int unsigned CTRL_TO_NS = 2;
	// status bit positions
	localparam int unsigned ST_FAULT = 0;
	localparam int unsigned ST_PE_ERR = 1;
	localparam int unsigned ST_PE_OK = 2;
	localparam int unsigned ST_W = 3;
	// reset values
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [ST_W-1:0] MASK_RST = 3'h0;
	localparam logic [7:0] PROT_RST = 8'h00;
endpackage : attr_pkg

// ==== dv/secure_memory_attribution_checker_asserts.sv ====
// port assertions for the attribution checker
`timescale 1ns/1ns
module secure_memory_attribution_checker_asserts (
	// observed ports
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic mem_valid,
	input wire logic [31:0] req_rdata,
	input wire logic fault_pulse,
	input wire logic fault_reset,
	input wire logic fault_nmi,
	input wire logic cpu_secure
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_blk; fault_pulse |-> req_valid && !mem_valid; endproperty
	a_blk: assert property (p_blk) else $error("fault passed on");
	property p_zero; req_valid && !req_write && !mem_valid |-> req_rdata == 32'h0; endproperty
	a_zero: assert property (p_zero) else $error("blocked data");
	// writes may still meet flash block protection, so only reads must pass
	property p_sec; req_valid && cpu_secure |-> !fault_pulse && (req_write || mem_valid); endproperty
	a_sec: assert property (p_sec) else $error("secure refused");
	property p_route; fault_pulse |-> fault_reset ^ fault_nmi; endproperty
	a_route: assert property (p_route) else $error("fault route");
	property p_idle; !req_valid |-> !(fault_pulse || fault_reset || fault_nmi); endproperty
	a_idle: assert property (p_idle) else $error("idle fault");
	property p_nsf; fault_pulse |-> !cpu_secure; endproperty
	a_nsf: assert property (p_nsf) else $error("secure fault");
	property p_one; !cpu_secure |=> !cpu_secure; endproperty
	a_one: assert property (p_one) else $error("back to secure");
	property p_rst; $rose(presetn) |-> cpu_secure; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	c_fault: cover property (fault_pulse);
	c_ns_ok: cover property (req_valid && !cpu_secure && mem_valid);
	c_drop: cover property ($fell(cpu_secure));
endmodule : secure_memory_attribution_checker_asserts
bind secure_memory_attribution_checker secure_memory_attribution_checker_asserts u_asserts (
	.pclk, .presetn, .req_valid, .req_write, .mem_valid, .req_rdata, .fault_pulse,
	.fault_reset, .fault_nmi, .cpu_secure);

// ==== dv/cpu_model.sv ====
// core model issuing accesses, with memory read data
`timescale 1ns/1ns
module cpu_model (
	// clock
	input wire logic pclk,
	// access and read data
	output logic req_valid,
	output logic req_write,
	output logic req_handler,
	output logic [31:0] req_addr,
	output logic [31:0] mem_rdata
);
	initial {req_valid, req_write, req_handler, req_addr} = 35'h0;
	// nonzero data so a zeroed blocked read shows
	assign mem_rdata = {req_addr[15:0], 16'ha5c3};
	task acc(input logic w, input logic [31:0] a);
		@(posedge pclk);
		{req_valid, req_write, req_addr} <= {1'b1, w, a};
		req_handler <= ~req_handler;
		@(negedge pclk);
	endtask : acc
endmodule : cpu_model

// ==== dv/secure_memory_attribution_checker_tb.sv ====
// table-driven bench for the attribution checker
`timescale 1ns/1ns
module secure_memory_attribution_checker_tb;
	typedef struct packed {logic w; logic [31:0] a; logic f; logic mv;} row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, nvm_load, irq, cpu_secure;
	logic req_valid, req_write, req_handler, mem_valid, fault_pulse, fault_reset, fault_nmi;
	logic [11:0] paddr;
	logic [15:0] nvm_kind, nvm_attr;
	logic [31:0] pwdata, prdata, req_addr, mem_rdata, req_rdata, rd;
	logic [255:0] nvm_base, nvm_limit;
	int fails, checked;
	row_s rows[7] = '{'{0, 32'h100, 1, 0}, '{0, 32'h1100, 0, 1}, '{1, 32'h1100, 0, 1},
		'{1, 32'h2000_0100, 1, 0}, '{0, 32'h2000_0100, 1, 0}, '{1, 32'h2000_1100, 1, 0},
		'{1, 32'h2000_2100, 0, 1}};
	secure_memory_attribution_checker #(.SEC_EXT(1'b1)) DUT (.pclk, .presetn, .clk_en(1'b1),
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
		.nvm_load, .secure_development_lifecycle_state(1'b1), .nvm_base, .nvm_limit, .nvm_kind,
		.nvm_attr, .req_valid, .req_write, .req_handler, .req_addr, .mem_rdata, .mem_valid,
		.req_rdata, .fault_pulse, .fault_reset, .fault_nmi, .irq, .cpu_secure);
	cpu_model cpu (.pclk, .req_valid, .req_write, .req_handler, .req_addr, .mem_rdata);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#80000 fails++;
		print_verdict();
	end
	task print_verdict();
		if (fails == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		fails += (g !== e);
		if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task run(input logic s);
		foreach (rows[i]) begin
			cpu.acc(rows[i].w, rows[i].a);
			chk("fault", !s & rows[i].f, fault_pulse);
			chk("pass", s | rows[i].mv, mem_valid);
			chk("nmi", !s & rows[i].f, fault_nmi);
			chk("rst_route", 0, fault_reset);
			if (!rows[i].w) chk("rdata", (s | rows[i].mv) ? mem_rdata : 32'h0, req_rdata);
		end
	endtask : run
	initial begin
		{presetn, psel, penable, pwrite, nvm_load, paddr, pwdata, fails, checked} = '0;
		{nvm_kind, nvm_attr} = {16'hfea0, 16'h0248};
		nvm_base = {96'h0, 32'h2000_2000, 32'h2000_1000, 32'h2000_0000, 32'h1000, 32'h0};
		nvm_limit = {96'h0, 32'h2000_2fff, 32'h2000_1fff, 32'h2000_0fff, 32'h1fff, 32'hfff};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk) nvm_load <= 1'b1;
		@(posedge pclk) nvm_load <= 1'b0;
		@(negedge pclk);
		chk("secure", 1, cpu_secure);
		run(1'b1);
		apb(1'b1, attr_pkg::OFS_CTRL, 32'h5);
		apb(1'b1, attr_pkg::OFS_MASK, 32'h1);
		@(negedge pclk);
		chk("nonsecure", 0, cpu_secure);
		run(1'b0);
		@(negedge pclk);
		chk("irq", 1, irq);
		apb(1'b1, attr_pkg::OFS_STATUS, 32'h7);
		apb(1'b1, attr_pkg::OFS_PE_REQ, 32'h1);
		apb(1'b0, attr_pkg::OFS_STATUS, 32'h0);
		chk("pe_err", 32'h2, rd);
		chk("irq_clr", 0, irq);
		apb(1'b0, 12'h0f0, 32'h0);
		chk("slverr", 1, err);
		print_verdict();
	end
endmodule : secure_memory_attribution_checker_tb
